// ### rcs_breaker_model.sv
`timescale 1ns/1ps

// Behavioural breaker: moves to the last commanded position after a travel time
module rcs_breaker_model #(
  parameter int TRAVEL = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Commands
  input wire logic open_i,
  input wire logic close_i,
  input wire logic manual_close_i,
  // Position
  output logic closed_o
);
  logic tgt_r;
  logic [3:0] cnt_r;

  // A held open level must not restart the travel, so only a new target does
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      closed_o <= 1'b1;
      tgt_r <= 1'b1;
      cnt_r <= 4'h0;
    end else if ((open_i && tgt_r) || ((close_i || manual_close_i) && !tgt_r)) begin
      tgt_r <= !open_i;
      cnt_r <= 4'h0;
    end else if (closed_o != tgt_r) begin
      cnt_r <= cnt_r + 4'h1;
      if (cnt_r == TRAVEL[3:0]) closed_o <= tgt_r;
    end
  end
endmodule : rcs_breaker_model

// ### rcs_map.svh
`ifndef RCS_MAP_SVH
`define RCS_MAP_SVH

// Register byte offsets on the Wishbone slave
`define RCS_A_CTRL 10'h000
`define RCS_A_SHOT_EN 10'h004
`define RCS_A_BLK_SEL 10'h008
`define RCS_A_RECLAIM 10'h00c
`define RCS_A_START 10'h010
`define RCS_A_STATUS 10'h020
// Timing memory window: dead times then discrimination times
`define RCS_A_MEM 10'h100
`define RCS_MEM_BIT 8

// Control register fields
`define RCS_CTRL_EN 0
`define RCS_CTRL_CBK 1

// Status register fields
`define RCS_ST_SHOT 0
`define RCS_ST_FT 5
`define RCS_ST_RUN 10
`define RCS_ST_REQ 11
`define RCS_ST_NUM 13
`define RCS_ST_STATE 16

// Reset values
`define RCS_RST_CTRL 2'h0
`define RCS_RST_SHOT_EN 20'h00000
`define RCS_RST_BLK_SEL 5'h00

// Time base: clock period, tick period and final-trip hold time
`define RCS_CLK_NS 5
`define RCS_TICK_NS 1000000
`define RCS_FT_MS 500
`define RCS_FT_TICKS (`RCS_FT_MS * 1000000 / `RCS_TICK_NS)

// Shape of the sequencer
`define RCS_NREQ 4
`define RCS_NSHOT 5
`define RCS_FT_CRIT 4

`endif

// ### rcs_mem.sv
`timescale 1ns/1ps

// Timing settings memory, one write port and one registered read port
module rcs_mem #(
  parameter int AW = 6,
  parameter int DW = 18
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Write port
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  // Read port
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem_r [0:(1<<AW)-1];

  // Storage write
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  // Registered read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else begin
      rdata_o <= mem_r[raddr_i];
    end
  end

endmodule : rcs_mem

// ### rcs_pkg.sv
package rcs_pkg;

  // Sequencer states, one-hot
  typedef enum logic [6:0] {
    RCS_READY   = 7'h01,
    RCS_OPEN    = 7'h02,
    RCS_DEAD    = 7'h04,
    RCS_CLOSEW  = 7'h08,
    RCS_DISCR   = 7'h10,
    RCS_RECLAIM = 7'h20,
    RCS_LOCKED  = 7'h40
  } rcs_state_t;

  // Shot search result: found flag and shot index
  typedef struct packed {
    logic found;
    logic [2:0] idx;
  } rcs_shot_t;

endpackage : rcs_pkg

// ### rcs_seq.sv
// What this block does
// - A shot whose block input is active is skipped as if absent.
// - Last shot blocked: request during previous shot's reclaim gives final trip.
// - Each request line has its own start delay; first expiry wins.
// - Simultaneous expiries pick the highest priority; line 1 highest, line 4 lowest.
// - On selection pick first enabled shot, open breaker, time dead time.
// - Each request line enables any combination of the five shots.
// - Starting at shot two or later uses previous shot's discrimination time.
// - Critical request in dead or discrimination time aborts with final trip.
// - Critical request is ignored when idle and during reclaim.
// - Start delay expiry sets the active indication of the first shot.
// - After successful reclose the shot indication holds until reclaim ends.
// - Failed reclose clears current shot indication and sets the next one.
// - Running is set once breaker is told open, cleared at close command.
// - Five final-trip outputs, one per request line plus critical.
// - A final-trip output stays high for half a second then clears.
// - Close-block input withholds only the breaker close command.
// - Close-block release with reclose pending closes the breaker at once.
// - Dead time expiry closes the breaker and starts discrimination time.
// - Reclaim expiry without request ends successfully back at ready.
// - After final trip stay locked until the breaker is closed manually.
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "rcs_map.svh"

module rcs_seq import rcs_pkg::*; #(
  parameter int TW = 18,
  parameter int TICK_CYC = `RCS_TICK_NS / `RCS_CLK_NS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Requests and blocking inputs
  input wire logic [3:0] reclose_req_i,
  input wire logic critical_req_i,
  input wire logic [4:0] shot_block_i,
  input wire logic close_block_i,
  // Breaker
  input wire logic breaker_closed_i,
  output logic breaker_open_o,
  output logic breaker_close_o,
  // Indications
  output logic [4:0] shot_active_o,
  output logic running_o,
  output logic [4:0] final_trip_o
);

  // First available shot at or above lo
  function automatic rcs_shot_t find_shot(input logic [4:0] m, input logic [2:0] lo);
    rcs_shot_t r;
    r = '0;
    for (int i = `RCS_NSHOT - 1; i >= 0; i--) begin
      if (m[i] && (3'(i) >= lo)) begin
        r.found = 1'b1;
        r.idx = 3'(i);
      end
    end
    return r;
  endfunction : find_shot

  // Byte-lane merge of a write into a register
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[b*8 +: 8] = n[b*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  localparam int TCW = $clog2(TICK_CYC + 1);

  rcs_state_t state_r, state_nxt;
  logic [1:0] ctrl_r;
  logic [19:0] shot_en_r;
  logic [4:0] blk_sel_r;
  logic [TW-1:0] reclaim_r;
  logic [TW-1:0] start_r [0:3];
  logic [TW-1:0] eff_start_r [0:3];
  logic [TW-1:0] st_cnt_r [0:3];
  logic [TW-1:0] tmr_r;
  logic [TW-1:0] ft_tmr_r;
  logic [TCW-1:0] div_r;
  logic tick_r;
  logic age_r;
  logic seen_open_r;
  logic [1:0] cur_req_r, req_nxt;
  logic [2:0] cur_shot_r, shot_nxt;
  logic [1:0] scan_r, scan_d_r;
  logic scan_first_d_r;
  logic fin, close_now;
  logic [2:0] fin_cause;

  // Bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i;            // Write lands at the ack edge
  wire mem_hit = wb_adr_i[`RCS_MEM_BIT];
  wire mem_we = bus_wr & mem_hit & (wb_sel_i == 4'hf);
  wire [5:0] mem_waddr = wb_adr_i[7:2];
  wire [TW-1:0] mem_q;

  // Shot availability: enabled and not blocked
  wire [4:0] blk_act = shot_block_i & blk_sel_r;
  wire [4:0] avail [0:3];
  wire rcs_shot_t first [0:3];
  wire [3:0] expired;
  genvar g;
  generate
    for (g = 0; g < `RCS_NREQ; g++) begin : g_req
      assign avail[g] = shot_en_r[g*`RCS_NSHOT +: `RCS_NSHOT] & ~blk_act;
      assign first[g] = find_shot(avail[g], 3'h0);
      assign expired[g] = reclose_req_i[g] & tick_r & first[g].found &
                          (st_cnt_r[g] >= eff_start_r[g]);
    end
  endgenerate

  // Priority pick among expired lines, line 1 first
  wire sel_vld = |expired;
  wire [1:0] sel_req = expired[0] ? 2'd0 : expired[1] ? 2'd1 :
                       expired[2] ? 2'd2 : 2'd3;
  wire rcs_shot_t nxt = find_shot(avail[cur_req_r], cur_shot_r + 3'h1);
  wire any_req = |reclose_req_i;
  wire en = ctrl_r[`RCS_CTRL_EN];
  wire cbk = close_block_i & ctrl_r[`RCS_CTRL_CBK];
  wire crit = critical_req_i;

  // Timing memory address: scan start delays when ready, else current shot
  wire rcs_shot_t scan_first = first[scan_r];
  wire [2:0] scan_prev = scan_first.idx - 3'h1;
  wire mem_dis = (state_r == RCS_DISCR);
  wire [5:0] mem_raddr = (state_r == RCS_READY) ? {1'b1, scan_r, scan_prev} :
                         {mem_dis, cur_req_r, cur_shot_r};
  wire [TW-1:0] target = (state_r == RCS_RECLAIM) ? reclaim_r : mem_q;
  wire expire = tick_r & age_r & (tmr_r >= target);

  rcs_mem #(
    .AW(6),
    .DW(TW)
  ) u_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(wb_dat_i[TW-1:0]),
    .raddr_i(mem_raddr),
    .rdata_o(mem_q)
  );

  // Sequence decisions
  always_comb begin
    state_nxt = state_r;
    req_nxt = cur_req_r;
    shot_nxt = cur_shot_r;
    fin = 1'b0;
    fin_cause = {1'b0, cur_req_r};
    close_now = 1'b0;
    unique case (state_r)
      RCS_READY: begin
        if (en && sel_vld) begin
          state_nxt = RCS_OPEN;
          req_nxt = sel_req;
          shot_nxt = first[sel_req].idx;
        end
      end
      RCS_OPEN, RCS_DEAD, RCS_CLOSEW: begin
        if (crit) begin
          fin = 1'b1;
          fin_cause = 3'(`RCS_FT_CRIT);
        end else if (state_r == RCS_OPEN) begin
          if (!breaker_closed_i) begin
            state_nxt = RCS_DEAD;
          end
        end else if ((state_r == RCS_DEAD && expire) || state_r == RCS_CLOSEW) begin
          if (cbk) begin
            state_nxt = RCS_CLOSEW;
          end else begin
            close_now = 1'b1;
            state_nxt = RCS_DISCR;
          end
        end
      end
      RCS_DISCR, RCS_RECLAIM: begin
        if (crit && state_r == RCS_DISCR) begin
          fin = 1'b1;
          fin_cause = 3'(`RCS_FT_CRIT);
        end else if (any_req) begin
          if (nxt.found) begin
            shot_nxt = nxt.idx;
            state_nxt = RCS_OPEN;
          end else begin
            fin = 1'b1;
          end
        end else if (expire) begin
          state_nxt = (state_r == RCS_DISCR) ? RCS_RECLAIM : RCS_READY;
        end
      end
      RCS_LOCKED: begin
        if (seen_open_r && breaker_closed_i) begin
          state_nxt = RCS_READY;
        end
      end
    endcase
    if (fin) begin
      state_nxt = RCS_LOCKED;
    end
  end

  // Shot indication follows the shot while a sequence is live
  wire live_nxt = (state_nxt != RCS_READY) && (state_nxt != RCS_LOCKED);
  wire [4:0] shot_oh = 5'h01 << shot_nxt;
  wire run_nxt = (state_nxt == RCS_OPEN) || (state_nxt == RCS_DEAD) ||
                 (state_nxt == RCS_CLOSEW);
  wire open_nxt = (state_nxt == RCS_OPEN && state_r != RCS_OPEN) ||
                  (state_nxt == RCS_OPEN && breaker_closed_i) ||
                  (state_nxt == RCS_LOCKED && breaker_closed_i && !(seen_open_r &&
                   state_r == RCS_LOCKED));

  // Common time-base tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else begin
      tick_r <= (div_r == TCW'(TICK_CYC - 1));
      div_r <= (div_r == TCW'(TICK_CYC - 1)) ? '0 : div_r + TCW'(1);
    end
  end

  // Per-line start delay counters, running only while ready
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < `RCS_NREQ; i++) begin
      if (rst_i || state_r != RCS_READY || !reclose_req_i[i]) begin
        st_cnt_r[i] <= '0;
      end else if (tick_r && st_cnt_r[i] != '1) begin
        st_cnt_r[i] <= st_cnt_r[i] + TW'(1);
      end
    end
  end

  // Effective start delay per line, refreshed by a rolling scan
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scan_r <= '0;
      scan_d_r <= '0;
      scan_first_d_r <= 1'b1;
      for (int i = 0; i < `RCS_NREQ; i++) begin
        eff_start_r[i] <= '0;
      end
    end else begin
      scan_r <= scan_r + 2'd1;
      scan_d_r <= scan_r;
      scan_first_d_r <= (scan_first.idx == 3'h0);
      if (state_r == RCS_READY && age_r) begin                          // Stale word on entry
        eff_start_r[scan_d_r] <= scan_first_d_r ? start_r[scan_d_r] : mem_q;
      end
    end
  end

  // Sequence state and shot timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= RCS_READY;
      cur_req_r <= '0;
      cur_shot_r <= '0;
      tmr_r <= '0;
      age_r <= 1'b0;
      seen_open_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cur_req_r <= req_nxt;
      cur_shot_r <= shot_nxt;
      age_r <= (state_nxt == state_r);
      tmr_r <= (state_nxt != state_r) ? '0 : tmr_r + TW'(tick_r);
      seen_open_r <= (state_r == RCS_LOCKED) & (seen_open_r | ~breaker_closed_i);
    end
  end

  // Breaker commands and indications
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      breaker_open_o <= 1'b0;
      breaker_close_o <= 1'b0;
      shot_active_o <= '0;
      running_o <= 1'b0;
    end else begin
      breaker_open_o <= open_nxt;
      breaker_close_o <= close_now;
      shot_active_o <= live_nxt ? shot_oh : 5'h00;
      running_o <= run_nxt;
    end
  end

  // Final-trip indication with automatic clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      final_trip_o <= '0;
      ft_tmr_r <= '0;
    end else if (fin) begin
      final_trip_o <= 5'h01 << fin_cause;
      ft_tmr_r <= '0;
    end else if (final_trip_o != 5'h00) begin
      ft_tmr_r <= ft_tmr_r + TW'(tick_r);
      if (tick_r && ft_tmr_r >= TW'(`RCS_FT_TICKS - 1)) begin
        final_trip_o <= '0;
      end
    end
  end

  // Register read mux
  wire [31:0] status = {9'h000, state_r, cur_shot_r, cur_req_r, running_o,
                        final_trip_o, shot_active_o};
  wire [3:0] st_idx = wb_adr_i[5:2] - 4'h4;
  wire start_hit = (wb_adr_i[9:4] == 6'(`RCS_A_START >> 4)) && !mem_hit;
  wire [31:0] rd_mux =
    (wb_adr_i == `RCS_A_CTRL) ? {30'h0, ctrl_r} :
    (wb_adr_i == `RCS_A_SHOT_EN) ? {12'h000, shot_en_r} :
    (wb_adr_i == `RCS_A_BLK_SEL) ? {27'h0, blk_sel_r} :
    (wb_adr_i == `RCS_A_RECLAIM) ? 32'(reclaim_r) :
    start_hit ? 32'(start_r[st_idx[1:0]]) :
    (wb_adr_i == `RCS_A_STATUS) ? status : 32'h0;

  // Wishbone answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : 32'h0;
    end
  end

  // Register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= `RCS_RST_CTRL;
      shot_en_r <= `RCS_RST_SHOT_EN;
      blk_sel_r <= `RCS_RST_BLK_SEL;
      reclaim_r <= '0;
      for (int i = 0; i < `RCS_NREQ; i++) begin
        start_r[i] <= '0;
      end
    end else if (bus_wr && !mem_hit) begin
      if (wb_adr_i == `RCS_A_CTRL) begin
        ctrl_r <= 2'(merge({30'h0, ctrl_r}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == `RCS_A_SHOT_EN) begin
        shot_en_r <= 20'(merge({12'h000, shot_en_r}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == `RCS_A_BLK_SEL) begin
        blk_sel_r <= 5'(merge({27'h0, blk_sel_r}, wb_dat_i, wb_sel_i));
      end
      if (wb_adr_i == `RCS_A_RECLAIM) begin
        reclaim_r <= TW'(merge(32'(reclaim_r), wb_dat_i, wb_sel_i));
      end
      if (start_hit) begin
        start_r[st_idx[1:0]] <= TW'(merge(32'(start_r[st_idx[1:0]]), wb_dat_i, wb_sel_i));
      end
    end
  end

endmodule : rcs_seq

// ### rcs_seq_assertions.sv
`timescale 1ns/1ps
`include "rcs_map.svh"

module rcs_seq_assertions #(
  parameter int TICK_CYC = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Watched ports
  input wire logic critical_req_i,
  input wire logic breaker_open_o,
  input wire logic breaker_close_o,
  input wire logic [4:0] shot_active_o,
  input wire logic running_o,
  input wire logic [4:0] final_trip_o
);
  localparam int FT = `RCS_FT_TICKS * TICK_CYC;
  int ft_n_r;

  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Cycles the final-trip output has been high
  always_ff @(posedge clk_i) begin
    if (rst_i || final_trip_o == 5'h00) ft_n_r <= 0;
    else ft_n_r <= ft_n_r + 1;
  end

  a_close_pulse: assert property (
    breaker_close_o |=> !breaker_close_o) else $error("close command too long");
  a_close_ends_run: assert property (
    breaker_close_o |-> !running_o && $past(running_o)) else $error("running not ended at close");
  a_open_on_start: assert property (
    $rose(running_o) |-> breaker_open_o) else $error("running without open command");
  a_run_has_shot: assert property (
    running_o |-> $onehot(shot_active_o)) else $error("running without one active shot");
  a_shot_onehot: assert property (
    $onehot0(shot_active_o)) else $error("several shots active");
  a_trip_onehot: assert property (
    $onehot0(final_trip_o)) else $error("several final-trip causes");
  a_trip_locks: assert property (
    $rose(|final_trip_o) |-> shot_active_o == 5'h00 && !running_o) else $error("trip not locked");
  a_crit_abort: assert property (
    critical_req_i && running_o |-> ##[1:4] final_trip_o[4]) else $error("critical not tripped");
  a_trip_hold: assert property (
    $fell(|final_trip_o) |-> ft_n_r > FT - 2 * TICK_CYC && ft_n_r < FT + 2 * TICK_CYC)
    else $error("final-trip hold time wrong");
endmodule : rcs_seq_assertions

bind rcs_seq rcs_seq_assertions #(.TICK_CYC(TICK_CYC)) u_rcs_chk (
  .clk_i(clk_i), .rst_i(rst_i), .critical_req_i(critical_req_i),
  .breaker_open_o(breaker_open_o), .breaker_close_o(breaker_close_o),
  .shot_active_o(shot_active_o), .running_o(running_o), .final_trip_o(final_trip_o));

// ### reclose_sequencer_test.sv
`timescale 1ns/1ps
`include "rcs_map.svh"

module reclose_sequencer_test;
  typedef struct packed {logic [3:0] req; logic [4:0] shot; logic [1:0] line;} rcs_row_t;
  rcs_row_t rows [5] = '{{4'h1, 5'h01, 2'h0}, {4'h2, 5'h04, 2'h1}, {4'h3, 5'h04, 2'h1},
                         {4'hc, 5'h02, 2'h2}, {4'h8, 5'h08, 2'h3}};
  logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, crit, cblk, man_cl;
  logic closed, open_c, close_c, run;
  logic [9:0] wb_adr;
  logic [3:0] wb_sel, req;
  logic [4:0] blk, shot, ftrip;
  logic [31:0] wb_wdat, wb_rdat, q;
  int err_count, check_count, cyc_n, ncl, i;
  longint t0;

  rcs_seq #(.TICK_CYC(4)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .reclose_req_i(req), .critical_req_i(crit), .shot_block_i(blk),
    .close_block_i(cblk), .breaker_closed_i(closed), .breaker_open_o(open_c),
    .breaker_close_o(close_c), .shot_active_o(shot), .running_o(run), .final_trip_o(ftrip));

  rcs_breaker_model u_brk (
    .clk_i(clk_i), .rst_i(rst_i), .open_i(open_c), .close_i(close_c),
    .manual_close_i(man_cl), .closed_o(closed));

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask : chk

  // One classic Wishbone cycle, held until ack
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    @(posedge clk_i iff wb_ack === 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : bus

  // Start a sequence on line 1 and drop the request once running
  task automatic start_line1();
    req <= 4'h1;
    @(posedge clk_i iff run === 1'b1);
    req <= 4'h0;
  endtask : start_line1

  // Manual close once the breaker is open
  task automatic unlock();
    @(posedge clk_i iff closed === 1'b0);
    man_cl <= 1'b1;
    @(posedge clk_i);
    man_cl <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : unlock

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // Hang guard and close-pulse counter
  always @(posedge clk_i) begin
    cyc_n++;
    if (close_c === 1'b1) ncl++;
    if (cyc_n == 40000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    {rst_i, wb_cyc, wb_stb, wb_we, crit, cblk, man_cl} = 7'h40;
    {wb_adr, wb_wdat, req, blk} = '0;
    wb_sel = 4'hf;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(0, `RCS_A_STATUS, 0);
    chk("status_rst", 32'h10000, q);
    bus(0, 10'h040, 0);
    chk("unmapped", 0, q);
    for (i = 0; i < 32; i++) begin
      bus(1, 10'h100 + 10'(i * 4), 32'h3);
      bus(1, 10'h180 + 10'(i * 4), 32'h4);
    end
    bus(1, `RCS_A_START, 32'h8);
    for (i = 1; i < 4; i++) bus(1, `RCS_A_START + 10'(i * 4), 32'hc);
    bus(1, `RCS_A_RECLAIM, 32'h14);
    bus(1, `RCS_A_SHOT_EN, 32'h40883);
    bus(1, `RCS_A_BLK_SEL, 32'h2);
    bus(1, `RCS_A_CTRL, 32'h1);
    crit <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("idle_crit", 0, ftrip);
    crit <= 1'b0;
    // Table of ordinary sequences
    foreach (rows[r]) begin
      req <= rows[r].req;
      @(posedge clk_i iff run === 1'b1);
      chk("first_shot", rows[r].shot, shot);
      chk("open_cmd", 1, open_c);
      bus(0, `RCS_A_STATUS, 0);
      chk("line", rows[r].line, q[12:11]);
      req <= 4'h0;
      @(posedge clk_i iff close_c === 1'b1);
      chk("run_at_close", 0, run);
      @(posedge clk_i iff shot === 5'h00);
      bus(0, `RCS_A_STATUS, 0);
      chk("ready", {9'h000, 7'h01, 3'($clog2(rows[r].shot)), rows[r].line, 11'h000}, q);
    end
    // Failed reclose, next shot, then a critical abort
    start_line1();
    @(posedge clk_i iff close_c === 1'b1);
    repeat (8) @(posedge clk_i);
    req <= 4'h1;
    @(posedge clk_i iff run === 1'b1);
    chk("next_shot", 5'h02, shot);
    req <= 4'h0;
    repeat (2) @(posedge clk_i);
    crit <= 1'b1;
    @(posedge clk_i iff ftrip !== 5'h00);
    t0 = $time;
    chk("crit_trip", 5'h10, ftrip);
    crit <= 1'b0;
    unlock();
    bus(0, `RCS_A_STATUS, 0);
    chk("unlocked", 7'h01, q[22:16]);
    @(posedge clk_i iff ftrip === 5'h00);
    chk("trip_hold", 1, ($time - t0) / 5 inside {[1996:2004]});
    // Last shot blocked, critical ignored in reclaim, request trips
    blk <= 5'h02;
    start_line1();
    @(posedge clk_i iff close_c === 1'b1);
    repeat (30) @(posedge clk_i);
    crit <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("reclaim_crit", 0, ftrip);
    chk("reclaim_shot", 5'h01, shot);
    crit <= 1'b0;
    req <= 4'h1;
    @(posedge clk_i iff ftrip !== 5'h00);
    chk("blk_trip", 5'h01, ftrip);
    req <= 4'h0;
    unlock();
    // Close-block withholds the reclose until released
    blk <= 5'h00;
    cblk <= 1'b1;
    bus(1, `RCS_A_CTRL, 32'h3);
    start_line1();
    i = ncl;
    repeat (80) @(posedge clk_i);
    chk("held", i, ncl);
    cblk <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("released", i + 1, ncl);
    @(posedge clk_i iff shot === 5'h00);
    conclude();
  end
endmodule : reclose_sequencer_test
